// ===== ldc_lamp_decode.sv
// Model of the external LED driver decode and gate pin wiring.
// Assumes the gate pins carry a pull-down resistor each.
`timescale 1ns/1ns
module ldc_lamp_decode
(
  input wire logic [1:0] choice,
  input wire logic [2:0] gate_out,
  input wire logic [2:0] gate_oe,
  output logic [2:0] lamp_en,
  output logic [2:0] gate_pin
);
  // ==========================================================
  // Decode and pin levels
  // ==========================================================
  // One-hot {blue,green,red}; code none enables nothing
  assign lamp_en = (choice == 2'h0) ? 3'h0 : 3'h1 << (choice - 2'h1);
  // Undriven pins fall to the pull-down level
  assign gate_pin = gate_out & gate_oe;
endmodule

// ===== ldc_pkg.sv
// Constants shared by the lamp drive control block.
// Assumes a 10 MHz core clock.
package ldc_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ = 10000000;
  localparam int DELAY_MS = 100;
  localparam int DELAY_CYC = (CLK_HZ / 1000) * DELAY_MS;
  localparam int CNT_W = 24;
  // ==========================================================
  // Lamp choice codes and PWM width
  // ==========================================================
  localparam logic [1:0] LAMP_NONE = 2'h0;
  localparam logic [1:0] LAMP_RED = 2'h1;
  localparam logic [1:0] LAMP_GREEN = 2'h2;
  localparam logic [1:0] LAMP_BLUE = 2'h3;
  localparam int PWM_W = 8;
endpackage

// ===== ldc_pwm_gen.sv
// Three-channel current PWM generator.
// Assumes duty values are stable on core_clk.
`timescale 1ns/1ns
module ldc_pwm_gen
  import ldc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  ldc_pwm_if.gen pif
);
  typedef struct packed {
    logic [PWM_W-1:0] cnt;
    logic [2:0] pwm;
  } ldc_pg_type;
  ldc_pg_type st_ff;
  ldc_pg_type nxt_st;
  logic [2:0] hit;
  // ==========================================================
  // Compare
  // ==========================================================
  assign hit[0] = st_ff.cnt < pif.duty_r;
  assign hit[1] = st_ff.cnt < pif.duty_g;
  assign hit[2] = st_ff.cnt < pif.duty_b;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cnt = st_ff.cnt + 1'b1;
    // Forced high stops current modulation outright
    nxt_st.pwm = pif.force_high ? 3'h7 : hit;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '{cnt: '0, pwm: 3'h7};
    else
      st_ff <= nxt_st;
  end
  assign pif.pwm = st_ff.pwm;
endmodule

// ===== ldc_pwm_if.sv
// Interface carrying duty values and forced-high control to the PWM unit.
// Assumes both ends share core_clk.
`timescale 1ns/1ns
interface ldc_pwm_if;
  import ldc_pkg::*;
  logic [PWM_W-1:0] duty_r;
  logic [PWM_W-1:0] duty_g;
  logic [PWM_W-1:0] duty_b;
  logic force_high;
  logic [2:0] pwm;
  modport ctl (output duty_r, output duty_g, output duty_b,
               output force_high, input pwm);
  modport gen (input duty_r, input duty_g, input duty_b,
               input force_high, output pwm);
endinterface

// ===== ldc_top.sv
// Lamp drive control: master-on delay, lamp choice, gates and PWM.
// Assumes asynchronous pin inputs and a 10 MHz core clock.
`timescale 1ns/1ns
module ldc_top
  import ldc_pkg::*;
#(
  parameter int DELAY_CYCLES = DELAY_CYC
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic lamp_permit_in,
  input wire logic park_n,
  input wire logic seq_running,
  input wire logic [1:0] seq_colour,
  input wire logic cfg_loaded,
  input wire logic sw_gate_write,
  input wire logic [2:0] sw_gate_en,
  input wire logic sw_lamp_ctrl_en,
  input wire logic [PWM_W-1:0] duty_red,
  input wire logic [PWM_W-1:0] duty_green,
  input wire logic [PWM_W-1:0] duty_blue,
  output logic red_current_pwm,
  output logic green_current_pwm,
  output logic blue_current_pwm,
  output logic lamp_choice_bit0,
  output logic lamp_choice_bit1,
  output logic lamp_driver_master_on,
  output logic [2:0] gate_out,
  output logic [2:0] gate_oe
);
  // Counter must be able to hold the whole delay
  if (DELAY_CYCLES < 1 || DELAY_CYCLES >= (1 << CNT_W))
  begin : g_bad_delay
    $error("DELAY_CYCLES out of range");
  end
  typedef struct packed {
    logic [1:0] perm_sync;
    logic [1:0] park_sync;
    logic [CNT_W-1:0] cnt;
    logic ready;
    logic master;
    logic [1:0] choice;
    logic gate_valid;
    logic [2:0] gate;
    logic [2:0] oe;
  } ldc_top_type;
  ldc_top_type st_ff;
  ldc_top_type nxt_st;
  ldc_pwm_if pif();
  logic perm;
  logic park_ok;
  assign perm = st_ff.perm_sync[1];
  assign park_ok = st_ff.park_sync[1];
  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    nxt_st = st_ff;
    // Pins cross in through two stages
    nxt_st.perm_sync = {st_ff.perm_sync[0], lamp_permit_in};
    nxt_st.park_sync = {st_ff.park_sync[0], park_n};
    if (!perm)
    begin
      nxt_st.cnt = '0;
      nxt_st.ready = 1'b0;
    end
    else if (!st_ff.ready)
    begin
      if (st_ff.cnt == CNT_W'(DELAY_CYCLES - 1))
        nxt_st.ready = 1'b1;
      else
        nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    // Drop uses next ready so permit low clears in the same edge
    nxt_st.master = nxt_st.ready && park_ok;
    nxt_st.choice = (nxt_st.ready && seq_running) ? seq_colour
                                                 : LAMP_NONE;
    // Outputs but idle until software writes the enables while cfg_loaded is high
    if (cfg_loaded)
      nxt_st.oe = 3'h7;
    if (cfg_loaded && sw_gate_write)
      nxt_st.gate_valid = 1'b1;
    if (sw_gate_write)
      nxt_st.gate = sw_gate_en;
    if (!nxt_st.gate_valid)
      nxt_st.gate = 3'h0;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  // ==========================================================
  // PWM
  // ==========================================================
  assign pif.duty_r = duty_red;
  assign pif.duty_g = duty_green;
  assign pif.duty_b = duty_blue;
  assign pif.force_high = !st_ff.master || !sw_lamp_ctrl_en
                          || !seq_running;
  ldc_pwm_gen u_pwm (
    .core_clk(core_clk),
    .nrst(nrst),
    .pif(pif.gen)
  );
  assign red_current_pwm = pif.pwm[0];
  assign green_current_pwm = pif.pwm[1];
  assign blue_current_pwm = pif.pwm[2];
  assign lamp_choice_bit0 = st_ff.choice[0];
  assign lamp_choice_bit1 = st_ff.choice[1];
  assign lamp_driver_master_on = st_ff.master;
  assign gate_out = st_ff.gate;
  assign gate_oe = st_ff.oe;
  // ==========================================================
  // Checks
  // ==========================================================
  // One clock domain, so one default clock and reset serve all
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_master_needs_perm: assert property (
    !perm |=> !lamp_driver_master_on
  )
  else
    $error("master on without permit");

  a_park_drops_master: assert property (
    !park_ok |=> !lamp_driver_master_on
  )
  else
    $error("master on in park");

  a_choice_none_idle: assert property (
    !perm |=> st_ff.choice == LAMP_NONE
  )
  else
    $error("choice not none");

  a_choice_none_stop: assert property (
    !seq_running |=> st_ff.choice == LAMP_NONE
  )
  else
    $error("choice not none while stopped");

  a_master_rise_delay: assert property (
    $rose(lamp_driver_master_on)
      |-> st_ff.cnt == CNT_W'(DELAY_CYCLES - 1)
  )
  else
    $error("master rose early");

  a_ready_after_count: assert property (
    $rose(st_ff.ready)
      |-> $past(perm) && ($past(st_ff.cnt) == CNT_W'(DELAY_CYCLES - 1))
  )
  else
    $error("release before delay");

  a_count_restart: assert property (
    !perm |=> st_ff.cnt == '0
  )
  else
    $error("count not restarted");

  a_gate_low_init: assert property (
    !st_ff.gate_valid |-> gate_out == 3'h0
  )
  else
    $error("gate active early");

  a_gate_oe_cfg: assert property (
    cfg_loaded |=> gate_oe == 3'h7
  )
  else
    $error("gate pins not outputs");

  // Force uses the registered master, so PWM follows one edge later
  a_pwm_forced_high: assert property (
    (!lamp_driver_master_on || !sw_lamp_ctrl_en || !seq_running)
      |=> {red_current_pwm, green_current_pwm, blue_current_pwm} == 3'h7
  )
  else
    $error("pwm not forced high");

  a_pwm_off_high: assert property (
    (!st_ff.master && !$past(st_ff.master))
      |=> {red_current_pwm, green_current_pwm, blue_current_pwm} == 3'h7
  )
  else
    $error("pwm not high while master off");

  a_choice_code: assert property (
    (nxt_st.ready && seq_running) |=> st_ff.choice == $past(seq_colour)
  )
  else
    $error("choice mismatch");
endmodule

// ===== test_led_drive_control.sv
// Self-checking bench for the lamp drive control block.
// Assumes ldc_pkg, ldc_pwm_if, the design and decode model compiled first.
`timescale 1ns/1ns
module test_led_drive_control;
  import ldc_pkg::*;
  // Short delay keeps the run small
  localparam int DLY = 20;
  logic core_clk, nrst, permit, park_n, run, cfg, wr, ctl, pr, pg, pb;
  logic c0, c1, mon;
  logic [1:0] colour;
  logic [2:0] gen, gate_out, gate_oe, lamp_en, gate_pin;
  logic [PWM_W-1:0] duty;
  logic [7:0] rows [4] = '{8'h08, 8'h51, 8'ha2, 8'hfc};
  int mismatches, comparisons, highs;
  ldc_top #(.DELAY_CYCLES(DLY)) u_ldc_top (.core_clk(core_clk),
    .nrst(nrst), .lamp_permit_in(permit), .park_n(park_n),
    .seq_running(run), .seq_colour(colour), .cfg_loaded(cfg),
    .sw_gate_write(wr), .sw_gate_en(gen), .sw_lamp_ctrl_en(ctl),
    .duty_red(duty), .duty_green(duty), .duty_blue(duty),
    .red_current_pwm(pr), .green_current_pwm(pg), .blue_current_pwm(pb),
    .lamp_choice_bit0(c0), .lamp_choice_bit1(c1),
    .lamp_driver_master_on(mon), .gate_out(gate_out), .gate_oe(gate_oe));
  ldc_lamp_decode u_ldc_lamp_decode (.choice({c1, c0}),
    .gate_out(gate_out), .gate_oe(gate_oe), .lamp_en(lamp_en),
    .gate_pin(gate_pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    {nrst, permit, run, cfg, wr, ctl, colour, gen, duty} = '0;
    park_n = 1'b1;
    tick(6);
    chk({pr, pg, pb, mon}, 8'h0e);
    @(posedge core_clk) nrst <= 1'b1;
    gen <= 3'h7;
    @(posedge core_clk) wr <= 1'b1;
    @(posedge core_clk) wr <= 1'b0;
    cfg <= 1'b1;
    tick(3);
    chk({gate_oe, gate_pin}, 8'h38);
    run <= 1'b1;
    colour <= 2'h2;
    permit <= 1'b1;
    tick(10);
    permit <= 1'b0;
    tick(2);
    permit <= 1'b1;
    tick(DLY + 1);
    chk({c1, c0, mon}, 8'h0);
    tick(3);
    chk({c1, c0, mon}, 8'h5);
    chk({pr, pg, pb}, 8'h7);
    ctl <= 1'b1;
    tick(3);
    chk({pr, pg, pb}, 8'h0);
    foreach (rows[i])
    begin
      colour <= rows[i][7:6];
      gen <= rows[i][5:3];
      wr <= 1'b1;
      @(posedge core_clk) wr <= 1'b0;
      tick(3);
      chk({c1, c0}, rows[i][7:6]);
      chk(lamp_en, rows[i][2:0]);
      chk(gate_pin, rows[i][5:3]);
    end
    // Quarter duty: 64 high cycles in any 256-cycle window
    duty <= 8'h40;
    highs = 0;
    tick(2);
    repeat (256)
    begin
      @(posedge core_clk);
      #1;
      if ({pr, pg, pb} === 3'h7)
        highs++;
    end
    chk(8'(highs), 8'h40);
    run <= 1'b0;
    tick(3);
    chk({pr, pg, pb}, 8'h7);
    run <= 1'b1;
    permit <= 1'b0;
    tick(3);
    chk({c1, c0, mon}, 8'h0);
    permit <= 1'b1;
    tick(DLY + 4);
    chk(mon, 1'b1);
    park_n <= 1'b0;
    tick(3);
    chk(mon, 1'b0);
    nrst <= 1'b0;
    tick(2);
    chk({pr, pg, pb, mon}, 8'h0e);
    end_sim();
  end
endmodule
